// ==== logic/gpio_spi_master.v ====
// Contract
// - Six pins, each set to input or output through its own pin_config.
// - Pull codes: 010 weak pull-up, 101 push-pull, 100 weak pull-down.
// - Fault-enabled pin at its fault level sets its fault flag, any direction; owned, addressing and converter pins never flag.
// - Pin level register shows every pin's current level, input or output.
// - Normal output pins drive the matching pin output value bit.
// - Enabled serial master owns pins 3 to 6; pins 1 and 2 stay normal.
// - Addressing select forces an unowned pin to input, ignoring other settings.
// - Pull code 000 selects converter input, ranked below addressing.
// - Temperature comparator faults flag regardless of pin configuration.
// - Master makes SCLK, drives MOSI and SS, samples MISO.
// - CPOL sets SCLK idle; CPHA picks leading or trailing sample edge.
// - CPHA clear: first bit before first edge, capture leading, change trailing.
// - CPHA set: first edge launches, capture trailing, change leading.
// - Bit count 1 to 8, sampled only when go starts a transfer.
// - Go starts one transfer, shifting transmit out while receiving.
// - Short transfers use low bits only, least significant bit first.
// - Select follows its bit; back-to-back transfers build longer words.
// - Pins 3 to 6 follow pin_config until master enable, then spi_cfg.
// - Config 0x08 selects low, 8 bits; 0x0C 4 bits; 0x18 deselects.
// - Serial execute write of 0x01 launches the configured transfer.
`timescale 1ns/10ps
`include "gpio_spi_master_regs.vh"

module gpio_spi_master (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [5:0]  pin_i,
  output reg  [5:0]  pin_o,
  output reg  [5:0]  pin_oe,
  output reg  [5:0]  pull_up_en,
  output reg  [5:0]  pull_down_en,
  output reg  [5:0]  converter_sel,
  input  wire [5:0]  over_temp_trip,
  input  wire [5:0]  under_temp_trip
);

  localparam [3:0] HALF_LAST = `SCLK_HALF_LAST;
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_SETUP = 4'h2;
  localparam [3:0] ST_RUN   = 4'h4;
  localparam [3:0] ST_HOLD  = 4'h8;
  // ========================================================================
  // Input synchronisers
  reg  [5:0]  pin_s1_q, pin_s2_q;
  reg  [5:0]  ot_s1_q, ot_s2_q;
  reg  [5:0]  ut_s1_q, ut_s2_q;

  // Pins and comparator trips come from outside mclk, two flops each
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      ot_s1_q  <= 6'h00;
      ot_s2_q  <= 6'h00;
      ut_s1_q  <= 6'h00;
      ut_s2_q  <= 6'h00;
    end else begin
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
      ot_s1_q  <= over_temp_trip;
      ot_s2_q  <= ot_s1_q;
      ut_s1_q  <= under_temp_trip;
      ut_s2_q  <= ut_s1_q;
    end
  end

  // ========================================================================
  // Register storage
  reg  [7:0]  cfg_q [0:5];
  reg  [5:0]  out_val_q;
  reg  [17:0] fault_q;
  reg  [7:0]  spi_cfg_q;
  reg  [7:0]  tx_q;
  reg  [7:0]  rx_q;
  reg         go_q;

  // ========================================================================
  // Write channel: address and data taken in either order, then answered
  reg         aw_full_q, w_full_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  wire        wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
  wire [5:0]  wr_idx  = aw_addr_q[7:2];
  wire        wr_hit  = (wr_idx <= `REG_LAST_INDEX) && (aw_addr_q[1:0] == 2'h0);
  wire [31:0] wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                         {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wr_bits = w_data_q & wr_mask;
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q    <= 1'b0;
      w_full_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2; // Unmapped answers SLVERR
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wr_pin_out = wr_fire && (aw_addr_q == `OFS_PIN_OUT);
  wire wr_fault   = wr_fire && (aw_addr_q == `OFS_PIN_FAULT);
  wire wr_spi_cfg = wr_fire && (aw_addr_q == `OFS_SPI_CFG) && w_strb_q[0];
  wire wr_tx      = wr_fire && (aw_addr_q == `OFS_SPI_TX) && w_strb_q[0];
  wire wr_exec    = wr_fire && (aw_addr_q == `OFS_SERIAL_EXEC) && w_strb_q[0];
  // ========================================================================
  // Control registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_val_q <= 6'h00;
      spi_cfg_q <= `RST_SPI_CFG;
      tx_q      <= `RST_BYTE;
      go_q      <= 1'b0;
    end else begin
      if (wr_pin_out && w_strb_q[0])
        out_val_q <= w_data_q[5:0];
      if (wr_spi_cfg)
        spi_cfg_q <= {1'b0, w_data_q[6:0]};
      if (wr_tx)
        tx_q <= w_data_q[7:0];
      go_q <= wr_exec && w_data_q[`EXEC_GO];
    end
  end

  wire       spi_en = spi_cfg_q[`SC_EN];
  wire       cpol   = spi_cfg_q[`SC_CPOL];
  wire [2:0] nb_fld = spi_cfg_q[`SC_NBITS_HI:`SC_NBITS_LO];
  // ========================================================================
  // Serial master engine
  reg  [3:0] st_q;
  reg  [3:0] half_q;
  reg  [3:0] edge_q;
  reg  [3:0] nbits_q;
  reg        cpha_q;
  reg        ph_q;
  reg        mosi_q;
  reg  [7:0] tx_sh_q;
  reg  [7:0] rx_sh_q;
  wire       half_end = (half_q == HALF_LAST);
  wire [2:0] bit_idx  = edge_q[3:1];
  wire [3:0] bit_next = {1'b0, bit_idx} + 4'h1;
  wire       lead     = !edge_q[0];
  wire       miso     = pin_s2_q[`PIN_MISO];
  wire       busy     = !st_q[0];
  // Shift is index based so short transfers touch only the low bits
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= ST_IDLE;
      half_q  <= 4'h0;
      edge_q  <= 4'h0;
      nbits_q <= 4'h8;
      cpha_q  <= 1'b0;
      ph_q    <= 1'b0;
      mosi_q  <= 1'b0;
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      rx_q    <= `RST_BYTE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          ph_q   <= 1'b0;
          half_q <= 4'h0;
          edge_q <= 4'h0;
          // Go while disabled or busy is dropped
          if (go_q && spi_en) begin
            st_q    <= ST_SETUP;
            nbits_q <= (nb_fld == 3'h0) ? 4'h8 : {1'b0, nb_fld};
            cpha_q  <= spi_cfg_q[`SC_CPHA];
            tx_sh_q <= tx_q;
            rx_sh_q <= rx_q;
            if (!spi_cfg_q[`SC_CPHA])
              mosi_q <= tx_q[0];
          end
        end
        ST_SETUP: begin
          // Half a bit here plus the first run half-bit: a full bit before the first edge
          half_q <= half_end ? 4'h0 : half_q + 4'h1;
          if (half_end)
            st_q <= ST_RUN;
        end
        ST_RUN: begin
          half_q <= half_end ? 4'h0 : half_q + 4'h1;
          if (half_end) begin
            ph_q   <= !ph_q;
            edge_q <= edge_q + 4'h1;
            if (lead) begin
              if (!cpha_q)
                rx_sh_q[bit_idx] <= miso;
              else
                mosi_q <= tx_sh_q[bit_idx];
            end else begin
              if (cpha_q)
                rx_sh_q[bit_idx] <= miso;
              else if (bit_next < nbits_q)
                mosi_q <= tx_sh_q[bit_next[2:0]];
              if (bit_next == nbits_q)
                st_q <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          // Clock back at idle for a half bit before the result lands
          half_q <= half_end ? 4'h0 : half_q + 4'h1;
          if (half_end) begin
            st_q <= ST_IDLE;
            rx_q <= rx_sh_q;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Values the master puts on its owned pins
  wire [5:0] spi_val;
  assign spi_val[1:0]       = 2'h0;
  assign spi_val[`PIN_SS]   = spi_cfg_q[`SC_SS_STAT];
  assign spi_val[`PIN_MOSI] = mosi_q;
  assign spi_val[`PIN_MISO] = 1'b0;
  assign spi_val[`PIN_SCLK] = ph_q ^ cpol;
  localparam [5:0] SPI_DRIVES = 6'h2c; // SS, MOSI and SCLK are outputs

  // ========================================================================
  // Per-pin function priority and fault detection
  wire [5:0] oe_d, o_d, pu_d, pd_d, adc_d, pin_flt;
  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_pin
      wire [7:0] c    = cfg_q[i];
      wire [2:0] pull = c[`PC_PULL_HI:`PC_PULL_LO];
      wire [1:0] fen  = c[`PC_FEN_HI:`PC_FEN_LO];
      wire       own  = spi_en && (i >= 2);
      wire       adr  = c[`PC_ADDR_SEL] && !own;
      wire       adc  = (pull == `PULL_ADC) && !own && !adr;
      wire       norm = !own && !adr && !adc;
      wire       lvl  = pin_s2_q[i];
      // Owned pins ignore direction, pulls and fault enable
      assign oe_d[i]    = own ? SPI_DRIVES[i] : (norm && !c[`PC_DIR_IN]);
      assign o_d[i]     = own ? spi_val[i] : out_val_q[i];
      assign pu_d[i]    = norm && (pull == `PULL_UP);
      assign pd_d[i]    = norm && (pull == `PULL_DOWN);
      assign adc_d[i]   = adc;
      assign pin_flt[i] = norm && (((fen == `FEN_HIGH) && lvl) ||
                                   ((fen == `FEN_LOW) && !lvl));
      // Pin config write, byte lane 0 only; a misaligned address must not land
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
          cfg_q[i] <= `RST_PIN_CONFIG;
        else if (wr_fire && wr_hit && w_strb_q[0] && (wr_idx == i))
          cfg_q[i] <= {1'b0, w_data_q[6:0]};
      end
    end
  endgenerate

  // Output pins drive both levels in every pull mode but converter code 000; weak modes also turn on their pull
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o         <= 6'h00;
      pin_oe        <= 6'h00;
      pull_up_en    <= 6'h00;
      pull_down_en  <= 6'h00;
      converter_sel <= 6'h00;
    end else begin
      pin_o         <= o_d;
      pin_oe        <= oe_d;
      pull_up_en    <= pu_d;
      pull_down_en  <= pd_d;
      converter_sel <= adc_d;
    end
  end

  // ========================================================================
  // Sticky fault flags, write one to clear; a new event beats the clear
  wire [17:0] flt_set = {ut_s2_q, ot_s2_q, pin_flt};
  wire [17:0] flt_clr = wr_fault ? wr_bits[17:0] : 18'h00000;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      fault_q <= 18'h00000;
    else
      fault_q <= flt_set | (fault_q & ~flt_clr);
  end

  // ========================================================================
  // Read channel: one read at a time, answered the cycle after the address
  reg [31:0] rd_mux;
  reg        rd_hit;
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  assign s_axi_arready = !s_axi_rvalid;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = (s_axi_araddr[1:0] == 2'h0);
    case (s_axi_araddr)
      `OFS_PIN_OUT:     rd_mux = {26'h0, out_val_q};
      `OFS_PIN_LEVEL:   rd_mux = {26'h0, pin_s2_q};
      `OFS_PIN_FAULT:   rd_mux = {14'h0, fault_q};
      `OFS_SPI_CFG:     rd_mux = {24'h0, spi_cfg_q};
      `OFS_SPI_TX:      rd_mux = {24'h0, tx_q};
      `OFS_SPI_RX:      rd_mux = {24'h0, rx_q};
      `OFS_SERIAL_EXEC: rd_mux = {30'h0, busy, 1'b0};
      default: begin
        if (rd_idx < 6'h06)
          rd_mux = {24'h0, cfg_q[rd_idx[2:0]]};
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? rd_mux : 32'h0000_0000;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== logic/gpio_spi_master_regs.vh ====
`ifndef GPIO_SPI_MASTER_REGS_VH
`define GPIO_SPI_MASTER_REGS_VH

// ==========================================================================
// Register byte offsets
`define OFS_PIN_CONFIG0   8'h00
`define OFS_PIN_OUT       8'h18
`define OFS_PIN_LEVEL     8'h1c
`define OFS_PIN_FAULT     8'h20
`define OFS_SPI_CFG       8'h24
`define OFS_SPI_TX        8'h28
`define OFS_SPI_RX        8'h2c
`define OFS_SERIAL_EXEC   8'h30
`define REG_LAST_INDEX    6'h0c

// ==========================================================================
// pin_config fields
`define PC_DIR_IN         0
`define PC_PULL_LO        1
`define PC_PULL_HI        3
`define PC_FEN_LO         4
`define PC_FEN_HI         5
`define PC_ADDR_SEL       6
`define PULL_ADC          3'h0
`define PULL_UP           3'h2
`define PULL_DOWN         3'h4
`define PULL_PUSH         3'h5
`define FEN_HIGH          2'h1
`define FEN_LOW           2'h2

// ==========================================================================
// spi_cfg fields
`define SC_NBITS_LO       0
`define SC_NBITS_HI       2
`define SC_EN             3
`define SC_SS_STAT        4
`define SC_CPOL           5
`define SC_CPHA           6
`define EXEC_GO           0
`define EXEC_BUSY         1

// ==========================================================================
// Pin roles while the serial master owns pins 3 to 6 (zero based index 2 to 5)
`define PIN_SS            2
`define PIN_MOSI          3
`define PIN_MISO          4
`define PIN_SCLK          5

// ==========================================================================
// Reset values
`define RST_PIN_CONFIG    8'h03
`define RST_SPI_CFG       8'h10
`define RST_BYTE          8'h00

// ==========================================================================
// Timing
// Half-bit is 8 mclk (64 ns at 125 MHz), counted from zero
`define SCLK_HALF_LAST    4'h7

`endif

// ==== tb/gpio_spi_master_sva.sv ====
`timescale 1ns/10ps
// ========================================================
// Port checks for the pin and serial master block
module gpio_spi_master_sva (
  input wire       mclk,
  input wire       rst_n,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire [5:0] pin_o,
  input wire [5:0] pin_oe,
  input wire [5:0] pull_up_en,
  input wire [5:0] pull_down_en,
  input wire [5:0] converter_sel
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Write answer one cycle after the pair is held, read answer one after the address
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && !s_axi_bvalid |=> ##1 s_axi_bvalid)
    else $error("late write response");
  AST_WR_RETIRE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  AST_RD_RETIRE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  // Weak pulls never fight, converter pins are never driven
  AST_PULL_EXCL: assert property ((pull_up_en & pull_down_en) == 6'h00)
    else $error("both pulls on one pin");
  AST_CONV_INPUT: assert property ((converter_sel & pin_oe) == 6'h00)
    else $error("converter pin driven");
  // Each clock phase lasts a half-bit; data only moves with a clock edge
  AST_SCLK_HALF: assert property ($changed(pin_o[5]) |=> $stable(pin_o[5]) [*7])
    else $error("clock phase too short");
  AST_MOSI_STEADY: assert property ($changed(pin_o[5]) && !pin_o[2]
    |=> $stable(pin_o[3]) [*7]) else $error("data moved mid phase");
endmodule

bind gpio_spi_master gpio_spi_master_sva u_gpio_spi_master_sva (
  .mclk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .pin_o, .pin_oe, .pull_up_en, .pull_down_en, .converter_sel
);

// ==== tb/spi_slave_model.sv ====
`timescale 1ns/10ps
// ========================================================
// Behavioural serial slave, least significant bit first
module spi_slave_model (
  input  wire         ss_n,
  input  wire         sclk,
  input  wire         mosi,
  input  wire         cpol,
  input  wire         cpha,
  input  wire  [15:0] sdo,
  output wire         miso,
  output logic [15:0] rx,
  output logic [4:0]  cnt
);
  logic miso_q = 1'b0;
  logic lead;
  // Released line shows the inverse so a stale bit never passes
  assign miso = ss_n ? ~miso_q : miso_q;
  // Leading-edge capture needs the first bit out at select
  always @(negedge ss_n) begin
    cnt = 5'd0;
    if (!cpha)
      miso_q = sdo[0];
  end
  // Capture on one edge kind, launch on the other
  always @(sclk) begin
    if (!ss_n) begin
      lead = (sclk !== cpol);
      if (lead ^ cpha) begin
        rx[cnt[3:0]] = mosi;
        cnt = cnt + 5'd1;
      end else
        miso_q = sdo[cnt[3:0]];
    end
  end
endmodule

// ==== tb/tb_gpio_spi_master.sv ====
`timescale 1ns/10ps
// ========================================================
// Register-level sequences against a behavioural slave
module tb_gpio_spi_master;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cpol = 1'b0, cpha = 1'b0;
  logic [5:0]  ext_q = 6'b000101, over_temp_trip = 6'h00, under_temp_trip = 6'h00;
  logic [15:0] sdo = 16'h0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [5:0]  pin_o, pin_oe, pull_up_en, pull_down_en, converter_sel, pin_i;
  wire         miso;
  wire  [15:0] srx;
  wire  [4:0]  scnt;
  int          fails = 0, n_tests = 0, cyc = 0, m;

  // Pad level: driven value where enabled, else the outside world
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & {ext_q[5], miso, ext_q[3:0]});

  gpio_spi_master u_gpio_spi_master (
    .mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_i, .pin_o, .pin_oe, .pull_up_en,
    .pull_down_en, .converter_sel, .over_temp_trip, .under_temp_trip
  );
  spi_slave_model u_spi_slave_model (
    .ss_n(pin_i[2]), .sclk(pin_i[5]), .mosi(pin_i[3]), .cpol, .cpha, .sdo, .miso,
    .rx(srx), .cnt(scnt)
  );

  // Clock and hang guard
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Handshakes judged from settled values, released just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'b00);
    logic ha, hw, hb;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(negedge mclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (ha)
        s_axi_awvalid <= 1'b0;
      if (hw)
        s_axi_wvalid <= 1'b0;
      if (hb)
        break;
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = 2'b00);
    logic ha, hr;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(negedge mclk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ha)
        s_axi_arvalid <= 1'b0;
      if (hr)
        break;
    end
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] k, e);
    rd(a, d);
    chk(nm, e, d & k);
  endtask

  // Poll busy; the short delay lets a fresh go raise it first
  task automatic wait_idle;
    repeat (4) @(posedge mclk);
    d = 32'h2;
    for (int i = 0; i < 100 && d[1]; i++)
      rd(8'h30, d);
    chk("exec", 32'h0, d & 32'h3);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge mclk);
    rc("cfg1 reset", 8'h00, 32'hffffffff, 32'h03);
    rc("spi reset", 8'h24, 32'hffffffff, 32'h10);
    rd(8'h34, d, 2'b10);
    chk("unmapped", 32'h0, d);
    wr(8'h34, 32'hff, 2'b10);
    wr(8'h00, 32'h15);
    wr(8'h04, 32'h0a);
    wr(8'h08, 32'h09);
    wr(8'h0c, 32'h01);
    wr(8'h10, 32'h4a);
    wr(8'h14, 32'h40);
    wr(8'h18, 32'h02);
    repeat (4) @(posedge mclk);
    chk("pull up", 32'h01, pull_up_en);
    chk("pull down", 32'h04, pull_down_en);
    chk("conv sel", 32'h08, converter_sel);
    chk("drive en", 32'h02, pin_oe);
    chk("drive val", 32'h1, pin_o[1]);
    rc("pin level", 8'h1c, 32'h3f, 32'h17);
    rc("pin fault", 8'h20, 32'h1, 32'h1);
    over_temp_trip <= 6'h20;
    under_temp_trip <= 6'h01;
    wr(8'h24, 32'h18);
    repeat (2) @(posedge mclk);
    chk("spi drive", 32'h2e, pin_oe);
    chk("spi pulls", 32'h0, {pull_down_en, converter_sel});
    for (m = 0; m < 4; m++) begin
      cpol <= m[0];
      cpha <= m[1];
      sdo <= 16'h073b + 16'(m);
      wr(8'h24, 32'h18 | (m << 5));
      wr(8'h28, 32'h3b);
      repeat (2) @(posedge mclk);
      chk("sclk idle", m & 1, pin_o[5]);
      wr(8'h24, 32'h08 | (m << 5));
      wr(8'h30, 32'h01);
      chk("ss low", 32'h0, pin_o[2]);
      rc("busy", 8'h30, 32'h3, 32'h2);
      wr(8'h24, 32'h0c | (m << 5));
      wr(8'h30, 32'h01);
      wait_idle;
      rc("rx byte", 8'h2c, 32'hff, 32'h3b + m);
      wr(8'h28, 32'h0b);
      wr(8'h30, 32'h01);
      wait_idle;
      rc("rx nibble", 8'h2c, 32'hff, 32'h37);
      wr(8'h24, 32'h18 | (m << 5));
      repeat (2) @(posedge mclk);
      chk("ss high", 32'h1, pin_o[2]);
      chk("slave bits", 32'd12, scnt);
      chk("slave data", 32'hb3b, srx[11:0]);
    end
    rc("temp flags", 8'h20, 32'h1800, 32'h1800);
    over_temp_trip <= 6'h00;
    under_temp_trip <= 6'h00;
    repeat (4) @(posedge mclk);
    // Pin 1 stays at its fault level, so its flag must come straight back
    wr(8'h20, 32'h1801);
    rc("flag clear", 8'h20, 32'h1801, 32'h1);
    finish_test;
  end
endmodule
